// [src/drive_status_defs.svh]
// Constants for the status indicator and serial command front end
`ifndef DRIVE_STATUS_DEFS_SVH
`define DRIVE_STATUS_DEFS_SVH

`define CLK_FREQ_HZ         50000000
`define FLASH_TIME_MS       250
`define FLASH_CYCLES        ((`CLK_FREQ_HZ / 1000) * `FLASH_TIME_MS)
`define PAUSE_TIME_MS       1500
`define PAUSE_CYCLES        ((`CLK_FREQ_HZ / 1000) * `PAUSE_TIME_MS)
`define TX_RELEASE_CYCLES   2

`define ERR_COUNT           9
`define ERR_STALL           0
`define ERR_MOVE_DISABLED   1
`define ERR_STACK_OVER      2
`define ERR_CCW_LIMIT       3
`define ERR_CW_LIMIT        4
`define ERR_STACK_UNDER     5
`define ERR_UNDERVOLT       6
`define ERR_BAD_INSTR       7
`define ERR_SERIAL          8

`define CHAR_CR             8'h0D
`define CHAR_EQ             8'h3D
`define CHAR_R              8'h52
`define CHAR_V              8'h56
`define CHAR_D              8'h44
`define CHAR_A              8'h41
`define CHAR_Z              8'h5A
`define ADDR_LOW            8'h21
`define ADDR_HIGH           8'h40
`define ADDR_RESET          8'h21
`define CMD_MAX             4

`endif

// [src/drive_status_pkg.sv]
// Types shared by the status indicator and serial command front end
package drive_status_pkg;
    typedef enum logic [1:0] {LED_SOLID, LED_RED, LED_GREEN, LED_PAUSE} led_phase_t;
    typedef enum logic [1:0] {CMD_IDLE, CMD_REPLY, CMD_RELEASE} cmd_state_t;
endpackage

// [src/status_flasher.sv]
// Bi-colour status indicator flash-code sequencer
`timescale 1ns/1ps
`include "drive_status_defs.svh"
module status_flasher #(
    parameter int FLASH_CYCLES = `FLASH_CYCLES,
    parameter int PAUSE_CYCLES = `PAUSE_CYCLES
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic [`ERR_COUNT-1:0]  error_flags,
    output logic                        led_red,
    output logic                        led_green
);
    typedef struct packed {
        drive_status_pkg::led_phase_t phase;
        logic [31:0]                  timer;
        logic [3:0]                   count;
        logic                         lit;
        logic [3:0]                   code;
        logic                         red;
        logic                         green;
    } flash_state_t;

    flash_state_t state_reg;
    flash_state_t state_next;
    logic         active;
    logic [3:0]   sel;
    logic [3:0]   reds;
    logic [3:0]   greens;

    // Lowest numbered active error wins
    always_comb begin
        active = |error_flags;
        sel    = 4'h0;
        for (int i = `ERR_COUNT - 1; i >= 0; i--) begin
            if (error_flags[i]) begin
                sel = 4'(i);
            end
        end
    end

    always_comb begin
        case (state_reg.code)
            4'h0: begin reds = 4'h1; greens = 4'h1; end
            4'h1: begin reds = 4'h1; greens = 4'h2; end
            4'h2: begin reds = 4'h1; greens = 4'h3; end
            4'h3: begin reds = 4'h2; greens = 4'h1; end
            4'h4: begin reds = 4'h2; greens = 4'h2; end
            4'h5: begin reds = 4'h2; greens = 4'h3; end
            4'h6: begin reds = 4'h4; greens = 4'h2; end
            4'h7: begin reds = 4'h4; greens = 4'h3; end
            default: begin reds = 4'h7; greens = 4'h1; end
        endcase
    end

    always_comb begin
        state_next = state_reg;
        state_next.timer = state_reg.timer + 32'h1;
        case (state_reg.phase)
            drive_status_pkg::LED_SOLID: begin
                state_next.red   = 1'b0;
                state_next.green = 1'b1;
                state_next.timer = 32'h0;
                if (active) begin
                    state_next.code  = sel;
                    state_next.phase = drive_status_pkg::LED_RED;
                    state_next.count = 4'h0;
                    state_next.lit   = 1'b1;
                    state_next.red   = 1'b1;
                    state_next.green = 1'b0;
                end
            end
            drive_status_pkg::LED_RED, drive_status_pkg::LED_GREEN: begin
                if (state_reg.timer == 32'(FLASH_CYCLES - 1)) begin
                    state_next.timer = 32'h0;
                    state_next.lit   = ~state_reg.lit;
                    if (state_reg.lit) begin
                        state_next.count = state_reg.count + 4'h1;
                        if (state_reg.phase == drive_status_pkg::LED_RED &&
                            state_reg.count + 4'h1 == reds) begin
                            state_next.phase = drive_status_pkg::LED_GREEN;
                            state_next.count = 4'h0;
                        end else if (state_reg.phase == drive_status_pkg::LED_GREEN &&
                                     state_reg.count + 4'h1 == greens) begin
                            state_next.phase = drive_status_pkg::LED_PAUSE;
                        end
                    end
                end
                state_next.red   = state_next.lit &&
                                   state_next.phase == drive_status_pkg::LED_RED;
                state_next.green = state_next.lit &&
                                   state_next.phase == drive_status_pkg::LED_GREEN;
            end
            drive_status_pkg::LED_PAUSE: begin
                state_next.red   = 1'b0;
                state_next.green = 1'b0;
                if (state_reg.timer == 32'(PAUSE_CYCLES - 1)) begin
                    state_next.timer = 32'h0;
                    state_next.phase = drive_status_pkg::LED_SOLID;
                    state_next.green = 1'b1;
                end
            end
            default: state_next.phase = drive_status_pkg::LED_SOLID;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '{drive_status_pkg::LED_SOLID, 32'h0, 4'h0, 1'b0, 4'h0, 1'b0, 1'b1};
        end else begin
            state_reg <= state_next;
        end
    end

    assign led_red   = state_reg.red;
    assign led_green = state_reg.green;
endmodule

// [src/bit_sync.sv]
// Two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    always_comb begin
        state_next.first  = async_in;
        state_next.second = state_reg.first;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.second;
endmodule

// [src/drive_front_end.sv]
// Status indicator and serial command front end of the drive
`timescale 1ns/1ps
`include "drive_status_defs.svh"
module drive_front_end #(
    parameter int         FLASH_CYCLES  = `FLASH_CYCLES,
    parameter int         PAUSE_CYCLES  = `PAUSE_CYCLES,
    parameter logic [7:0] FW_VERSION    = 8'h31,
    parameter int         RELEASE_CYCLES = `TX_RELEASE_CYCLES
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic [`ERR_COUNT-1:0]  error_pins,
    output logic                        led_red,
    output logic                        led_green,
    input  wire logic [7:0]             rx_data,
    input  wire logic                   rx_valid,
    input  wire logic                   rx_busy,
    output logic [7:0]                  tx_data,
    output logic                        tx_valid,
    input  wire logic                   tx_ready,
    input  wire logic                   tx_busy,
    output logic                        tx_enable,
    output logic [7:0]                  drive_address
);
    typedef struct packed {
        drive_status_pkg::cmd_state_t state;
        logic [7:0]                   buf0;
        logic [7:0]                   buf1;
        logic [7:0]                   buf2;
        logic [7:0]                   buf3;
        logic [2:0]                   len;
        logic                         overrun;
        logic [7:0]                   addr;
        logic [7:0]                   r0;
        logic [7:0]                   r1;
        logic [7:0]                   r2;
        logic [7:0]                   r3;
        logic [2:0]                   rlen;
        logic [2:0]                   ridx;
        logic [7:0]                   txd;
        logic                         txv;
        logic                         txen;
        logic [3:0]                   hold;
    } cmd_reg_t;

    cmd_reg_t               state_reg;
    cmd_reg_t               state_next;
    logic [`ERR_COUNT-1:0]  err_sync;
    logic [7:0]             c0;
    logic [7:0]             c1;
    logic [7:0]             c2;
    logic [1:0]             body_len;
    logic                   prefixed;
    logic                   is_rv;
    logic                   is_da;
    logic                   is_da_set;

    bit_sync #(
        .WIDTH    (`ERR_COUNT)
    ) bit_sync_inst (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in (error_pins),
        .sync_out (err_sync)
    );

    status_flasher #(
        .FLASH_CYCLES (FLASH_CYCLES),
        .PAUSE_CYCLES (PAUSE_CYCLES)
    ) status_flasher_inst (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .error_flags  (err_sync),
        .led_red      (led_red),
        .led_green    (led_green)
    );

    // Decode the buffered line: a leading character that is not an uppercase
    // letter is an address prefix
    always_comb begin
        prefixed = state_reg.len != 3'h0 &&
                   !(state_reg.buf0 >= `CHAR_A && state_reg.buf0 <= `CHAR_Z);
        c0 = prefixed ? state_reg.buf1 : state_reg.buf0;
        c1 = prefixed ? state_reg.buf2 : state_reg.buf1;
        c2 = prefixed ? state_reg.buf3 : state_reg.buf2;
        body_len = prefixed ? 2'(state_reg.len - 3'h1) : 2'(state_reg.len);
        if (prefixed && state_reg.len == 3'h4) begin
            body_len = 2'h3;
        end else if (!prefixed && state_reg.len >= 3'h4) begin
            body_len = 2'h0;
        end
        // Exact byte compares, so lowercase letters never match
        is_rv     = body_len == 2'h2 && c0 == `CHAR_R && c1 == `CHAR_V;
        is_da     = body_len == 2'h2 && c0 == `CHAR_D && c1 == `CHAR_A;
        is_da_set = body_len == 2'h3 && c0 == `CHAR_D && c1 == `CHAR_A &&
                    c2 >= `ADDR_LOW && c2 <= `ADDR_HIGH;
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg.state)
            drive_status_pkg::CMD_IDLE: begin
                state_next.txen = 1'b0;
                if (rx_valid) begin
                    if (rx_data == `CHAR_CR) begin
                        state_next.len     = 3'h0;
                        state_next.overrun = 1'b0;
                        // Foreign prefix: drop silently, transmitter untouched
                        if (!state_reg.overrun && (!prefixed ||
                            state_reg.buf0 == state_reg.addr)) begin
                            state_next.r0   = c0;
                            state_next.r1   = c1;
                            state_next.r2   = `CHAR_EQ;
                            state_next.rlen = 3'h4;
                            state_next.ridx = 3'h0;
                            if (is_rv) begin
                                state_next.r3    = FW_VERSION;
                                state_next.state = drive_status_pkg::CMD_REPLY;
                            end else if (is_da) begin
                                state_next.r3    = state_reg.addr;
                                state_next.state = drive_status_pkg::CMD_REPLY;
                            end else if (is_da_set) begin
                                state_next.addr = c2;
                            end
                        end
                    end else if (state_reg.len == 3'(`CMD_MAX)) begin
                        state_next.overrun = 1'b1;
                    end else begin
                        case (state_reg.len)
                            3'h0: state_next.buf0 = rx_data;
                            3'h1: state_next.buf1 = rx_data;
                            3'h2: state_next.buf2 = rx_data;
                            default: state_next.buf3 = rx_data;
                        endcase
                        state_next.len = state_reg.len + 3'h1;
                    end
                end
            end
            drive_status_pkg::CMD_REPLY: begin
                // Hold the line while the host is still sending
                if (!rx_busy) begin
                    state_next.txen = 1'b1;
                end
                if (state_reg.txv && tx_ready) begin
                    state_next.txv = 1'b0;
                    if (state_reg.ridx == state_reg.rlen) begin
                        state_next.state = drive_status_pkg::CMD_RELEASE;
                        state_next.hold  = 4'h0;
                    end else begin
                        state_next.ridx = state_reg.ridx + 3'h1;
                    end
                end else if (!state_reg.txv && state_reg.txen) begin
                    state_next.txv = 1'b1;
                    case (state_reg.ridx)
                        3'h0: state_next.txd = state_reg.r0;
                        3'h1: state_next.txd = state_reg.r1;
                        3'h2: state_next.txd = state_reg.r2;
                        3'h3: state_next.txd = state_reg.r3;
                        default: state_next.txd = `CHAR_CR;
                    endcase
                end
            end
            drive_status_pkg::CMD_RELEASE: begin
                // Drop the driver a fixed few cycles after the last stop bit
                if (!tx_busy) begin
                    state_next.hold = state_reg.hold + 4'h1;
                    if (state_reg.hold == 4'(RELEASE_CYCLES - 1)) begin
                        state_next.txen  = 1'b0;
                        state_next.state = drive_status_pkg::CMD_IDLE;
                    end
                end
            end
            default: state_next.state = drive_status_pkg::CMD_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= '0;
            state_reg.addr <= `ADDR_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tx_data       = state_reg.txd;
    assign tx_valid      = state_reg.txv;
    assign tx_enable     = state_reg.txen;
    assign drive_address = state_reg.addr;
endmodule

// [sim/drive_front_end_properties.sv]
// Concurrent checks on the drive front end ports
`timescale 1ns/1ps
`include "drive_status_defs.svh"
module drive_front_end_properties #(
    parameter int FLASH_CYCLES = 4,
    parameter int PAUSE_CYCLES = 8
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic [`ERR_COUNT-1:0] error_pins,
    input  wire logic                  led_red,
    input  wire logic                  led_green,
    input  wire logic                  rx_busy,
    input  wire logic [7:0]            tx_data,
    input  wire logic                  tx_valid,
    input  wire logic                  tx_ready,
    input  wire logic                  tx_busy,
    input  wire logic                  tx_enable,
    input  wire logic [7:0]            drive_address
);
    // Longest code plus pause, with margin for the pin synchroniser
    localparam int QUIET = 24 * FLASH_CYCLES + PAUSE_CYCLES + 8;
    logic [15:0] red_run_reg;
    logic [15:0] quiet_reg;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            red_run_reg <= 16'h0000;
            quiet_reg   <= 16'h0000;
        end else begin
            red_run_reg <= led_red ? red_run_reg + 16'h0001 : 16'h0000;
            quiet_reg   <= (error_pins != '0) ? 16'h0000 : quiet_reg + 16'h0001;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence quiet_then_error;
        quiet_reg > QUIET && error_pins != '0;
    endsequence
    sequence first_red;
        ##[2:4] (led_red && !led_green);
    endsequence
    solid_green_a: assert property (quiet_reg > QUIET |-> led_green && !led_red)
        else $error("indicator not solid green while idle");
    red_onset_a: assert property (quiet_then_error |-> first_red)
        else $error("indicator did not turn red on error");
    colour_excl_a: assert property (!(led_red && led_green))
        else $error("both colours lit together");
    flash_len_a: assert property ($fell(led_red) |-> red_run_reg == 16'(FLASH_CYCLES))
        else $error("red flash length wrong");
    half_duplex_a: assert property ($rose(tx_enable) |-> !$past(rx_busy))
        else $error("transmitter enabled while host sending");
    valid_in_en_a: assert property (tx_valid |-> tx_enable)
        else $error("byte offered with transmitter released");
    reply_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped before handshake");
    release_a: assert property ($fell(tx_enable) |-> !$past(tx_busy) && !$past(tx_valid))
        else $error("transmitter released while sending");
    addr_range_a: assert property (drive_address >= `ADDR_LOW && drive_address <= `ADDR_HIGH)
        else $error("stored address out of range");
endmodule
bind drive_front_end drive_front_end_properties #(
    .FLASH_CYCLES(FLASH_CYCLES), .PAUSE_CYCLES(PAUSE_CYCLES)
) drive_front_end_properties_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .error_pins(error_pins), .led_red(led_red),
    .led_green(led_green), .rx_busy(rx_busy), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_busy(tx_busy), .tx_enable(tx_enable),
    .drive_address(drive_address)
);

// [sim/host_link_model.sv]
// Host side of the serial link: sends command lines, collects reply bytes
`timescale 1ns/1ps
`include "drive_status_defs.svh"
module host_link_model (
    input  wire logic       ref_clk,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    output logic            rx_busy,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic            tx_busy,
    input  wire logic       tx_enable
);
    logic [7:0] got[$];
    integer     seed = 32;
    logic [2:0] shift_reg = 3'h0;
    initial begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
        rx_busy  = 1'b0;
        tx_ready = 1'b0;
        tx_busy  = 1'b0;
    end
    // Reply bytes are taken at a random pace; the shifter stays busy a while after each
    always @(posedge ref_clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
            tx_ready  <= 1'b0;
            shift_reg <= 3'h4;
        end else begin
            tx_ready  <= tx_valid && shift_reg == 3'h0 && $random(seed) % 2 == 0;
            shift_reg <= (shift_reg != 3'h0) ? shift_reg - 3'h1 : 3'h0;
        end
        tx_busy <= (tx_valid && tx_ready) || shift_reg > 3'h1;
    end
    task automatic send_byte(input logic [7:0] b);
        @(posedge ref_clk);
        while (tx_enable) @(posedge ref_clk);
        rx_busy <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rx_busy  <= 1'b0;
        rx_valid <= 1'b1;
        rx_data  <= b;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_data  <= ~b;
    endtask
    task automatic send_line(input string s);
        for (int i = 0; i < s.len(); i++) send_byte(s[i]);
        send_byte(`CHAR_CR);
    endtask
endmodule

// [sim/drive_front_end_bench.sv]
// Self-checking bench for the status indicator and serial command front end
`timescale 1ns/1ps
`include "drive_status_defs.svh"
module drive_front_end_bench;
    localparam logic [7:0] FW = 8'h37;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [`ERR_COUNT-1:0] error_pins = '0;
    logic led_red, led_green, rx_valid, rx_busy, tx_valid, tx_ready, tx_busy, tx_enable;
    logic [7:0] rx_data, tx_data, drive_address, a, o;
    integer errors = 0;
    integer checked = 0;
    integer seed = 32;
    integer reds_exp[9] = '{1, 1, 1, 2, 2, 2, 4, 4, 7};
    integer greens_exp[9] = '{1, 2, 3, 1, 2, 3, 2, 3, 1};
    drive_front_end #(
        .FLASH_CYCLES(4), .PAUSE_CYCLES(8), .FW_VERSION(FW), .RELEASE_CYCLES(2)
    ) drive_front_end_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .error_pins(error_pins), .led_red(led_red),
        .led_green(led_green), .rx_data(rx_data), .rx_valid(rx_valid), .rx_busy(rx_busy),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_busy(tx_busy),
        .tx_enable(tx_enable), .drive_address(drive_address)
    );
    host_link_model host_link_model_inst (
        .ref_clk(ref_clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_busy(rx_busy),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_busy(tx_busy),
        .tx_enable(tx_enable)
    );
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic int lowest(input logic [`ERR_COUNT-1:0] m);
        for (int i = 0; i < `ERR_COUNT; i++) if (m[i]) return i;
        return 0;
    endfunction
    // Raise a fault pattern after a long quiet spell, drop it once red shows
    // unless held, then count one whole code
    task automatic flash_case(input logic [`ERR_COUNT-1:0] mask, input logic hold);
        integer k, reds, greens, dark, n;
        logic pr, pg;
        k = lowest(mask);
        repeat (120) @(posedge ref_clk);
        @(posedge ref_clk) error_pins <= mask;
        for (n = 0; n < 10 && led_red !== 1'b1; n++) @(negedge ref_clk);
        @(posedge ref_clk) error_pins <= hold ? mask : '0;
        reds = 1;
        greens = 0;
        dark = 0;
        pr = 1'b1;
        pg = 1'b0;
        for (n = 0; n < 300 && dark < 7; n++) begin
            @(negedge ref_clk);
            reds += (led_red && !pr);
            greens += (led_green && !pg);
            dark = (led_red || led_green) ? 0 : dark + 1;
            pr = led_red;
            pg = led_green;
        end
        check(reds, reds_exp[k], "red flashes");
        check(greens, greens_exp[k], "green flashes");
        for (n = 0; n < 20 && led_green !== 1'b1; n++) @(negedge ref_clk);
        if (hold) begin
            @(negedge ref_clk);
            check({led_red, led_green}, 2'b10, "code repeats");
            @(posedge ref_clk) error_pins <= '0;
        end else begin
            repeat (3) @(negedge ref_clk);
            check({led_red, led_green}, 2'b01, "solid green after code");
        end
    endtask
    // Send one line; an empty reply means the transmitter must stay released
    task automatic expect_reply(input string cmd, input string rep);
        integer n;
        host_link_model_inst.got.delete();
        host_link_model_inst.send_line(cmd);
        for (n = 0; n < 20 && tx_enable !== 1'b1; n++) @(negedge ref_clk);
        check(tx_enable, rep.len() != 0, "transmitter enable");
        for (n = 0; n < 400 && tx_enable !== 1'b0; n++) @(negedge ref_clk);
        n = (rep.len() != 0) ? rep.len() + 1 : 0;
        check(host_link_model_inst.got.size(), n, "reply length");
        foreach (host_link_model_inst.got[i])
            check(host_link_model_inst.got[i], (i < rep.len()) ? rep[i] : `CHAR_CR, "byte");
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        check({led_red, led_green, tx_enable}, 3'b010, "reset outputs");
        check(drive_address, `ADDR_RESET, "reset address");
        for (int i = 0; i < 15; i++)
            flash_case((i < 9) ? 9'h001 << i : 9'($random(seed)) | 9'h100, i == 14);
        expect_reply("RV", $sformatf("RV=%c", FW));
        expect_reply("DA", "DA=!");
        expect_reply("rv", "");
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 8'h40 : 8'h21 + 8'($unsigned($random(seed)) % 32);
            o = 8'h21 + 8'((a - 8'h20) % 32);
            expect_reply($sformatf("DA%c", a), "");
            check(drive_address, a, "stored address");
            expect_reply($sformatf("%cRV", a), $sformatf("RV=%c", FW));
            expect_reply($sformatf("%cDA", o), "");
            expect_reply("DA", $sformatf("DA=%c", a));
        end
        // Too long a line is dropped whole; the next one still works
        expect_reply("RVRVR", "");
        expect_reply("RV", $sformatf("RV=%c", FW));
        expect_reply($sformatf("%cDA#", a), "");
        check(drive_address, 8'h23, "prefixed store");
        expect_reply("DA~", "");
        check(drive_address, 8'h23, "out of range kept");
        report_and_stop();
    end
endmodule
